// *** include/pwr_mode_pkg.sv ***
/*
  Constants for the low power mode controller: register map, field
  positions, reset values and timing counts.
  Assumes a 40 MHz system clock and a 32-bit AXI4-Lite register bus.
*/
package pwr_mode_pkg;
  // Clock
  localparam int CLK_HZ = 40_000_000;
  // Register byte offsets
  localparam logic [7:0] OFS_SCRATCH0 = 8'h00;
  localparam logic [7:0] OFS_SCRATCH15 = 8'h3C;
  localparam logic [7:0] OFS_MODE_CTRL = 8'h40;
  localparam logic [7:0] OFS_WAKE_POL = 8'h44;
  localparam logic [7:0] OFS_WAKE_EN = 8'h48;
  localparam logic [7:0] OFS_WAKE_FLAGS = 8'h4C;
  localparam logic [7:0] OFS_STATUS = 8'h50;
  localparam int SCRATCH_WORDS = 16;
  localparam int SCRATCH_BITS = 8;
  localparam int WAKE_PINS_N = 12;
  // power_mode_control fields
  localparam int LIGHT_NAP_BIT = 2;
  localparam int DEEP_NAP_BIT = 1;
  localparam int FULL_OFF_BIT = 0;
  localparam logic [2:0] MODE_CTRL_RST = 3'h0;
  localparam logic [7:0] SCRATCH_RST = 8'h00;
  localparam logic [11:0] WAKE_POL_RST = 12'h000;
  localparam logic [11:0] WAKE_EN_RST = 12'h000;
  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Timing: flash wake after deep nap, system reset pulse length
  localparam int FLASH_WAKE_NS = 10000;
  localparam int FLASH_WAKE_CYC = (FLASH_WAKE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int SYS_RST_NS = 100;
  localparam int SYS_RST_CYC = (SYS_RST_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam logic [8:0] FLASH_WAKE_LOAD = 9'(FLASH_WAKE_CYC);
  localparam logic [8:0] SYS_RST_LOAD = 9'(SYS_RST_CYC);
  // Power states
  typedef enum logic [2:0] {
    ST_RUN, ST_NAP, ST_DEEP, ST_FLASH_WAKE, ST_OFF, ST_POWER_UP, ST_RESET_OUT
  } pwr_state_t;
endpackage : pwr_mode_pkg

// *** verilog/low_power_mode_controller.sv ***
/*
  Low power mode controller: normal, light nap, deep nap and full off
  sequencing, retained scratch words, port 0 wake edge logic and an
  AXI4-Lite register slave.
  Assumes the core pulses WFI_EXEC for one cycle per wait-for-interrupt,
  NRST is removed only with all power, and all inputs are synchronous.
*/
// Added by the designer: the placing of the registers and the AXI4-Lite register port.
// Operation
// [R1] Light nap stops core clock until wake
// [R2] Gated peripherals run in light nap
// [R3] Naps keep state, registers, pins static
// [R4] Any interrupt ends light nap
// [R5] External reset works during both naps
// [R6] Software sets light nap select, then WAIT_FOR_INTERRUPT_INSTR
// [R7] Deep nap stops clocks, oscillators; RTC kept
// [R8] Deep nap ends on port wake, RTC
// [R9] Software sets deep nap select, then WAIT_FOR_INTERRUPT_INSTR
// [R10] Flash powers down, longer wake delay
// [R11] Full off drops regulator and clocks
// [R12] Wake pin high to enter, low exits
// [R13] Only scratch words survive full off; the code also keeps mode control
// [R14] Wake pin fall: regulator on, then reset
// [R15] External reset ignored during full off
// [R16] Software raises pin, sets full off, WAIT_FOR_INTERRUPT_INSTR
// [R17] Software waits over 20 us before WAIT_FOR_INTERRUPT_INSTR
// [R18] After WAIT_FOR_INTERRUPT_INSTR regulator off, await pin
// [R19] Wake reset spares scratch and mode control
// [R20] Software reads then clears full off select
// [R21] Port wake edge only, per-pin polarity
// [R22] Twelve wake pins share interrupt line 0
// [R23] Mode control bits 2,1,0, reset zero
// [R24] Scratch words hold eight bits each
// [R25] Full off beats deep nap beats light
module low_power_mode_controller (
  // Clock, power-on reset, clock enable
  input wire logic CLK,
  input wire logic NRST,
  input wire logic CE,
  // AXI4-Lite slave
  input wire logic [7:0] AWADDR,
  input wire logic AWVALID,
  output logic AWREADY,
  input wire logic [31:0] WDATA,
  input wire logic [3:0] WSTRB,
  input wire logic WVALID,
  output logic WREADY,
  output logic [1:0] BRESP,
  output logic BVALID,
  input wire logic BREADY,
  input wire logic [7:0] ARADDR,
  input wire logic ARVALID,
  output logic ARREADY,
  output logic [31:0] RDATA,
  output logic [1:0] RRESP,
  output logic RVALID,
  input wire logic RREADY,
  // Core and interrupt side
  input wire logic WFI_EXEC,
  input wire logic ANY_IRQ,
  input wire logic IRQ0_ENABLED,
  input wire logic RTC_IRQ,
  input wire logic RTC_SLOW_CLK_USED,
  output logic WAKE_IRQ0,
  // Pins and supplies
  input wire logic [pwr_mode_pkg::WAKE_PINS_N-1:0] WAKE_PINS,
  input wire logic OFF_STATE_WAKE_PIN,
  input wire logic EXT_RESET_N,
  input wire logic CORE_SUPPLY_OK,
  input wire logic [31:0] BUS_CLOCK_GATES,
  // Clock and power controls
  output logic CORE_CLK_EN,
  output logic [31:0] PERIPH_CLK_EN,
  output logic FAST_OSC_EN,
  output logic SLOW_OSC_EN,
  output logic FLASH_PWR_EN,
  output logic PIN_HOLD,
  output logic REGULATOR_EN,
  output logic SYS_RESET
);
  import pwr_mode_pkg::*;

  pwr_state_t state_reg, state_next;
  logic [2:0] mode_ctrl_reg;
  logic [SCRATCH_BITS-1:0] scratch_reg [SCRATCH_WORDS];
  logic [11:0] wake_pol_reg, wake_en_reg, wake_flags_reg, pins_prev_reg;
  logic [8:0] cnt_reg;
  logic wake_pin_prev_reg;
  logic [7:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic aw_have_reg, w_have_reg;
  logic [31:0] wmask;
  logic do_write, sys_rst, ext_rst, deep_wake, pin_fall;
  logic [11:0] edge_hit;
  logic [31:0] rd_word;
  logic rd_ok, wr_ok;

  // Internal system reset clears wake polarity, enable and flags; scratch and mode control are kept
  assign sys_rst = (state_reg == ST_RESET_OUT); // see [R19]
  // External reset only counts while the core supply is up
  assign ext_rst = !EXT_RESET_N && (state_reg != ST_OFF)
                   && (state_reg != ST_POWER_UP); // see [R5] see [R15]
  assign pin_fall = wake_pin_prev_reg && !OFF_STATE_WAKE_PIN; // see [R14]
  assign deep_wake = ((|wake_flags_reg) && IRQ0_ENABLED) || RTC_IRQ; // see [R8] see [R21]

  // Edge detect on each enabled port 0 wake pin, polarity per pin
  genvar gi;
  generate
    for (gi = 0; gi < WAKE_PINS_N; gi++) begin : g_edge
      assign edge_hit[gi] = wake_en_reg[gi] && (wake_pol_reg[gi] ?
        (!pins_prev_reg[gi] && WAKE_PINS[gi]) :
        (pins_prev_reg[gi] && !WAKE_PINS[gi])); // see [R21]
    end
  endgenerate

  // Next power state; priority among selects when WAIT_FOR_INTERRUPT_INSTR is taken
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ST_RUN: begin
        if (WFI_EXEC) begin
          if (mode_ctrl_reg[FULL_OFF_BIT]) begin
            state_next = ST_OFF; // see [R25] see [R18]
          end else if (mode_ctrl_reg[DEEP_NAP_BIT]) begin
            state_next = ST_DEEP; // see [R25]
          end else if (mode_ctrl_reg[LIGHT_NAP_BIT]) begin
            state_next = ST_NAP; // see [R1]
          end
        end
      end
      ST_NAP: begin
        if (ANY_IRQ) begin
          state_next = ST_RUN; // see [R4]
        end
      end
      ST_DEEP: begin
        if (deep_wake) begin
          state_next = ST_FLASH_WAKE; // see [R8]
        end
      end
      ST_FLASH_WAKE: begin
        if (cnt_reg == 9'h000) begin
          state_next = ST_RUN; // see [R10]
        end
      end
      ST_OFF: begin
        if (pin_fall) begin
          state_next = ST_POWER_UP; // see [R14]
        end
      end
      ST_POWER_UP: begin
        if (CORE_SUPPLY_OK) begin
          state_next = ST_RESET_OUT; // see [R14]
        end
      end
      ST_RESET_OUT: begin
        if (cnt_reg == 9'h000) begin
          state_next = ST_RUN;
        end
      end
    endcase
    if (ext_rst) begin
      state_next = ST_RUN; // see [R5]
    end
  end

  // State register
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      state_reg <= ST_RUN;
    end else if (CE) begin
      state_reg <= state_next;
    end
  end

  // Shared down counter for flash wake delay and reset pulse
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      cnt_reg <= 9'h000;
    end else if (CE) begin
      if (state_reg == ST_DEEP && state_next == ST_FLASH_WAKE) begin
        cnt_reg <= FLASH_WAKE_LOAD - 9'h001; // see [R10]
      end else if (state_reg == ST_POWER_UP && state_next == ST_RESET_OUT) begin
        cnt_reg <= SYS_RST_LOAD - 9'h001;
      end else if (cnt_reg != 9'h000) begin
        cnt_reg <= cnt_reg - 9'h001;
      end
    end
  end

  // Wake pin history; the pin is watched in every state
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      wake_pin_prev_reg <= 1'b0;
      pins_prev_reg <= 12'h000;
    end else if (CE) begin
      wake_pin_prev_reg <= OFF_STATE_WAKE_PIN; // see [R12]
      pins_prev_reg <= WAKE_PINS;
    end
  end

  // Clock, power and reset outputs, all registered from the next state; SYS_RESET also from ext_rst
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      CORE_CLK_EN <= 1'b1;
      PERIPH_CLK_EN <= 32'h0000_0000;
      FAST_OSC_EN <= 1'b1;
      SLOW_OSC_EN <= 1'b1;
      FLASH_PWR_EN <= 1'b1;
      PIN_HOLD <= 1'b0;
      REGULATOR_EN <= 1'b1;
      SYS_RESET <= 1'b0;
    end else if (CE) begin
      CORE_CLK_EN <= (state_next == ST_RUN); // see [R1] see [R7]
      PERIPH_CLK_EN <= (state_next == ST_RUN || state_next == ST_NAP) ?
                       BUS_CLOCK_GATES : 32'h0000_0000; // see [R2] see [R7]
      FAST_OSC_EN <= (state_next == ST_RUN || state_next == ST_NAP
                      || state_next == ST_FLASH_WAKE); // see [R7]
      // Slow oscillator survives deep nap only if the RTC runs from it
      SLOW_OSC_EN <= (state_next == ST_DEEP) ? RTC_SLOW_CLK_USED :
                     (state_next != ST_OFF && state_next != ST_POWER_UP); // see [R7] see [R11]
      FLASH_PWR_EN <= (state_next != ST_DEEP && state_next != ST_OFF
                       && state_next != ST_POWER_UP); // see [R10]
      PIN_HOLD <= (state_next == ST_NAP || state_next == ST_DEEP); // see [R3]
      REGULATOR_EN <= (state_next != ST_OFF); // see [R11] see [R18] see [R14]
      SYS_RESET <= ext_rst || (state_next == ST_RESET_OUT); // see [R14] see [R5]
    end
  end

  // AXI write capture: address and data accepted in either order
  assign do_write = aw_have_reg && w_have_reg && !BVALID;
  assign wmask = {{8{w_strb_reg[3]}}, {8{w_strb_reg[2]}},
                  {8{w_strb_reg[1]}}, {8{w_strb_reg[0]}}};
  assign wr_ok = (aw_addr_reg[1:0] == 2'h0) && (aw_addr_reg <= OFS_STATUS);

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      aw_have_reg <= 1'b0;
      w_have_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_data_reg <= 32'h0000_0000;
      w_strb_reg <= 4'h0;
      AWREADY <= 1'b0;
      WREADY <= 1'b0;
      BVALID <= 1'b0;
      BRESP <= RESP_OKAY;
    end else if (CE) begin
      AWREADY <= !aw_have_reg && !AWREADY;
      WREADY <= !w_have_reg && !WREADY;
      if (AWVALID && AWREADY) begin
        aw_have_reg <= 1'b1;
        aw_addr_reg <= AWADDR;
        AWREADY <= 1'b0;
      end
      if (WVALID && WREADY) begin
        w_have_reg <= 1'b1;
        w_data_reg <= WDATA;
        w_strb_reg <= WSTRB;
        WREADY <= 1'b0;
      end
      if (do_write) begin
        BVALID <= 1'b1;
        BRESP <= wr_ok ? RESP_OKAY : RESP_SLVERR;
        aw_have_reg <= 1'b0;
        w_have_reg <= 1'b0;
      end else if (BVALID && BREADY) begin
        BVALID <= 1'b0;
      end
    end
  end

  // Mode control: survives the wake reset, cleared only at power-on
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      mode_ctrl_reg <= MODE_CTRL_RST; // see [R23]
    end else if (CE && do_write && aw_addr_reg == OFS_MODE_CTRL && w_strb_reg[0]) begin
      mode_ctrl_reg <= w_data_reg[2:0]; // see [R23] see [R20]
    end
  end

  // Scratch words: low byte only, untouched by the system reset
  generate
    for (gi = 0; gi < SCRATCH_WORDS; gi++) begin : g_scratch
      always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
          scratch_reg[gi] <= SCRATCH_RST; // see [R24]
        end else if (CE && do_write && w_strb_reg[0]
                     && aw_addr_reg == OFS_SCRATCH0 + 8'(gi * 4)) begin
          scratch_reg[gi] <= w_data_reg[7:0]; // see [R13] see [R24]
        end
      end
    end
  endgenerate

  // Wake configuration, cleared by the wake system reset (ST_RESET_OUT), not by the external reset
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      wake_pol_reg <= WAKE_POL_RST;
      wake_en_reg <= WAKE_EN_RST;
    end else if (CE) begin
      if (sys_rst) begin
        wake_pol_reg <= WAKE_POL_RST; // see [R19]
        wake_en_reg <= WAKE_EN_RST;
      end else if (do_write && aw_addr_reg == OFS_WAKE_POL) begin
        wake_pol_reg <= (wake_pol_reg & ~wmask[11:0]) | (w_data_reg[11:0] & wmask[11:0]);
      end else if (do_write && aw_addr_reg == OFS_WAKE_EN) begin
        wake_en_reg <= (wake_en_reg & ~wmask[11:0]) | (w_data_reg[11:0] & wmask[11:0]);
      end
    end
  end

  // Sticky wake flags, write one to clear; a new edge beats the clear
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      wake_flags_reg <= 12'h000;
    end else if (CE) begin
      if (sys_rst) begin
        wake_flags_reg <= 12'h000; // see [R19]
      end else if (do_write && aw_addr_reg == OFS_WAKE_FLAGS) begin
        wake_flags_reg <= (wake_flags_reg & ~(w_data_reg[11:0] & wmask[11:0]))
                          | edge_hit; // see [R21]
      end else begin
        wake_flags_reg <= wake_flags_reg | edge_hit;
      end
    end
  end

  // Every enabled pin of the twelve drives the single shared line
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      WAKE_IRQ0 <= 1'b0;
    end else if (CE) begin
      WAKE_IRQ0 <= |(wake_flags_reg | edge_hit); // see [R22]
    end
  end

  // Read decode; reserved bits read zero
  always_comb begin
    rd_word = 32'h0000_0000;
    rd_ok = 1'b1;
    if (ARADDR[1:0] != 2'h0) begin
      rd_ok = 1'b0;
    end else if (ARADDR <= OFS_SCRATCH15) begin
      rd_word = {24'h000000, scratch_reg[ARADDR[5:2]]};
    end else if (ARADDR == OFS_MODE_CTRL) begin
      rd_word = {29'h0, mode_ctrl_reg};
    end else if (ARADDR == OFS_WAKE_POL) begin
      rd_word = {20'h00000, wake_pol_reg};
    end else if (ARADDR == OFS_WAKE_EN) begin
      rd_word = {20'h00000, wake_en_reg};
    end else if (ARADDR == OFS_WAKE_FLAGS) begin
      rd_word = {20'h00000, wake_flags_reg};
    end else if (ARADDR == OFS_STATUS) begin
      rd_word = {29'h0, state_reg};
    end else begin
      rd_ok = 1'b0;
    end
  end

  // AXI read channel: one read under way at a time
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      ARREADY <= 1'b0;
      RVALID <= 1'b0;
      RDATA <= 32'h0000_0000;
      RRESP <= RESP_OKAY;
    end else if (CE) begin
      ARREADY <= !RVALID && !ARREADY && !(ARVALID && ARREADY);
      if (ARVALID && ARREADY) begin
        RVALID <= 1'b1;
        RDATA <= rd_word;
        RRESP <= rd_ok ? RESP_OKAY : RESP_SLVERR;
        ARREADY <= 1'b0;
      end else if (RVALID && RREADY) begin
        RVALID <= 1'b0;
      end
    end
  end
endmodule : low_power_mode_controller

// *** verification/pwr_mode_checker.sv ***
/*
  Checker: power sequencing relations seen at the controller ports.
  Assumes CE is held high and inputs change just after rising edges.
*/
module pwr_mode_checker
  import pwr_mode_pkg::*;
(
  // Clock and reset
  input wire logic CLK,
  input wire logic NRST,
  // Inputs watched
  input wire logic EXT_RESET_N,
  input wire logic ANY_IRQ,
  input wire logic OFF_STATE_WAKE_PIN,
  input wire logic RTC_SLOW_CLK_USED,
  input wire logic [31:0] BUS_CLOCK_GATES,
  // Outputs watched
  input wire logic CORE_CLK_EN,
  input wire logic [31:0] PERIPH_CLK_EN,
  input wire logic FAST_OSC_EN,
  input wire logic SLOW_OSC_EN,
  input wire logic FLASH_PWR_EN,
  input wire logic PIN_HOLD,
  input wire logic REGULATOR_EN,
  input wire logic SYS_RESET
);
  logic fw;
  logic [9:0] fw_cnt;
  // Flash wake window: flash up, core still held, not in reset
  assign fw = FLASH_PWR_EN && !CORE_CLK_EN && !PIN_HOLD && !SYS_RESET;
  // Counts the window so the long wait needs no long repetition
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      fw_cnt <= 10'h000;
    end else begin
      fw_cnt <= fw ? fw_cnt + 10'h001 : 10'h000;
    end
  end
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!NRST);
  AST_NAP_GATES: assert property (PIN_HOLD && FAST_OSC_EN |->
    !CORE_CLK_EN && PERIPH_CLK_EN == $past(BUS_CLOCK_GATES)) else $error("nap clocks wrong");
  AST_DEEP_STOP: assert property (PIN_HOLD && !FAST_OSC_EN |->
    PERIPH_CLK_EN == 32'h0 && SLOW_OSC_EN == $past(RTC_SLOW_CLK_USED)) else $error("deep clocks");
  AST_OFF_DARK: assert property (!REGULATOR_EN |->
    !CORE_CLK_EN && !FAST_OSC_EN && !SLOW_OSC_EN && PERIPH_CLK_EN == 32'h0)
    else $error("off state clocks");
  AST_NAP_IRQ_WAKE: assert property (PIN_HOLD && FAST_OSC_EN && ANY_IRQ && EXT_RESET_N
    |=> CORE_CLK_EN) else $error("nap not ended by irq");
  AST_NAP_EXT_RST: assert property (PIN_HOLD && !EXT_RESET_N |=> SYS_RESET)
    else $error("reset lost in nap");
  AST_OFF_EXT_IGNORED: assert property (!REGULATOR_EN && !EXT_RESET_N && OFF_STATE_WAKE_PIN
    |=> !SYS_RESET && !REGULATOR_EN) else $error("reset acted in off");
  AST_OFF_PIN_WAKE: assert property (!REGULATOR_EN && $past(OFF_STATE_WAKE_PIN)
    && !OFF_STATE_WAKE_PIN |=> REGULATOR_EN) else $error("pin fall ignored");
  AST_FLASH_WAKE_LEN: assert property (fw && EXT_RESET_N ##1 CORE_CLK_EN && !SYS_RESET
    |-> fw_cnt == 10'(FLASH_WAKE_CYC)) else $error("flash wake length");
  AST_BOOT_RESET_LEN: assert property ($rose(SYS_RESET) && !$past(FLASH_PWR_EN)
    |-> SYS_RESET [*4] ##1 !SYS_RESET) else $error("boot reset length");
  cover property (PIN_HOLD && FAST_OSC_EN ##1 CORE_CLK_EN);
  cover property (fw ##1 CORE_CLK_EN);
  cover property (!REGULATOR_EN ##1 REGULATOR_EN);
endmodule : pwr_mode_checker

bind low_power_mode_controller pwr_mode_checker u_chk (.CLK, .NRST, .EXT_RESET_N, .ANY_IRQ,
  .OFF_STATE_WAKE_PIN, .RTC_SLOW_CLK_USED, .BUS_CLOCK_GATES, .CORE_CLK_EN, .PERIPH_CLK_EN,
  .FAST_OSC_EN, .SLOW_OSC_EN, .FLASH_PWR_EN, .PIN_HOLD, .REGULATOR_EN, .SYS_RESET);

// *** verification/core_side_model.sv ***
/*
  Model of the core, the wake pin driver and the core supply.
  Assumes the supply needs SUP_DLY cycles to settle after power-up.
*/
module core_side_model #(
  parameter int SUP_DLY = 6
) (
  // Clock and regulator control
  input wire logic CLK,
  input wire logic REGULATOR_EN,
  // Core events, wake pin, supply status
  output logic WFI_EXEC,
  output logic ANY_IRQ,
  output logic OFF_STATE_WAKE_PIN,
  output logic CORE_SUPPLY_OK
);
  int ramp;
  // Wake pin idles high so full off can be entered
  initial begin
    WFI_EXEC = 1'b0;
    ANY_IRQ = 1'b0;
    OFF_STATE_WAKE_PIN = 1'b1;
    CORE_SUPPLY_OK = 1'b1;
    ramp = SUP_DLY;
  end
  // Supply drops at once but ramps slowly, so the reset waits on it
  always @(posedge CLK) begin
    ramp <= !REGULATOR_EN ? 0 : (ramp < SUP_DLY ? ramp + 1 : ramp);
    CORE_SUPPLY_OK <= REGULATOR_EN && ramp >= SUP_DLY;
  end
  // One-cycle pulse; the select bits are written beforehand
  task automatic wait_for_interrupt_instr();
    @(posedge CLK);
    WFI_EXEC <= 1'b1;
    @(posedge CLK);
    WFI_EXEC <= 1'b0;
  endtask : wait_for_interrupt_instr
  task automatic irq();
    @(posedge CLK);
    ANY_IRQ <= 1'b1;
    @(posedge CLK);
    ANY_IRQ <= 1'b0;
  endtask : irq
  task automatic pin(input logic v);
    @(posedge CLK);
    OFF_STATE_WAKE_PIN <= v;
  endtask : pin
endmodule : core_side_model

// *** verification/low_power_mode_controller_tb_top.sv ***
/*
  Testbench: register access, light nap, deep nap and full off sequences.
  Assumes the core_side_model partner and the bound checker.
*/
module low_power_mode_controller_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import pwr_mode_pkg::*;
  logic CLK, NRST, CE, AWVALID, AWREADY, WVALID, WREADY, BVALID, BREADY;
  logic ARVALID, ARREADY, RVALID, RREADY, WFI_EXEC, ANY_IRQ, IRQ0_ENABLED, RTC_IRQ;
  logic RTC_SLOW_CLK_USED, WAKE_IRQ0, OFF_STATE_WAKE_PIN, EXT_RESET_N, CORE_SUPPLY_OK;
  logic CORE_CLK_EN, FAST_OSC_EN, SLOW_OSC_EN, FLASH_PWR_EN, PIN_HOLD, REGULATOR_EN, SYS_RESET;
  logic [7:0] AWADDR, ARADDR;
  logic [31:0] WDATA, RDATA, BUS_CLOCK_GATES, PERIPH_CLK_EN, rd;
  logic [3:0] WSTRB;
  logic [1:0] BRESP, RRESP, rsp;
  logic [WAKE_PINS_N-1:0] WAKE_PINS;
  int errors, compares;
  low_power_mode_controller DUT (.CLK, .NRST, .CE, .AWADDR, .AWVALID, .AWREADY, .WDATA,
    .WSTRB, .WVALID, .WREADY, .BRESP, .BVALID, .BREADY, .ARADDR, .ARVALID, .ARREADY, .RDATA,
    .RRESP, .RVALID, .RREADY, .WFI_EXEC, .ANY_IRQ, .IRQ0_ENABLED, .RTC_IRQ, .RTC_SLOW_CLK_USED,
    .WAKE_IRQ0, .WAKE_PINS, .OFF_STATE_WAKE_PIN, .EXT_RESET_N, .CORE_SUPPLY_OK,
    .BUS_CLOCK_GATES, .CORE_CLK_EN, .PERIPH_CLK_EN, .FAST_OSC_EN, .SLOW_OSC_EN,
    .FLASH_PWR_EN, .PIN_HOLD, .REGULATOR_EN, .SYS_RESET);
  core_side_model core (.CLK, .REGULATOR_EN, .WFI_EXEC, .ANY_IRQ, .OFF_STATE_WAKE_PIN,
    .CORE_SUPPLY_OK);
  // 40 MHz clock
  initial begin
    CLK = 1'b0;
    forever #12.5 CLK = ~CLK;
  end
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", compares, errors);
    if (errors == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : report_and_stop
  // Address and data offered together, each dropped when its ready is seen
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    @(posedge CLK);
    AWADDR <= a;
    WDATA <= d;
    AWVALID <= 1'b1;
    WVALID <= 1'b1;
    BREADY <= 1'b1;
    do begin
      @(posedge CLK);
      if (AWVALID && AWREADY) AWVALID <= 1'b0;
      if (WVALID && WREADY) WVALID <= 1'b0;
    end while (!BVALID);
    BREADY <= 1'b0;
    rsp = BRESP;
  endtask : axw
  task automatic axr(input logic [7:0] a);
    @(posedge CLK);
    ARADDR <= a;
    ARVALID <= 1'b1;
    RREADY <= 1'b1;
    do begin
      @(posedge CLK);
      if (ARVALID && ARREADY) ARVALID <= 1'b0;
    end while (!RVALID);
    RREADY <= 1'b0;
    rd = RDATA;
    rsp = RRESP;
  endtask : axr
  task automatic t_regs();
    axr(OFS_MODE_CTRL);
    chk("mode ctrl reset", 32'h0, rd);
    axw(OFS_MODE_CTRL, 32'hFFFF_FFFF);
    axr(OFS_MODE_CTRL);
    chk("mode ctrl bits", 32'h7, rd);
    axw(OFS_SCRATCH0 + 8'h14, 32'h1234_56A7);
    axr(OFS_SCRATCH0 + 8'h14);
    chk("scratch", 32'hA7, rd);
    axr(8'h80);
    chk("unmapped resp", RESP_SLVERR, rsp);
    axw(OFS_MODE_CTRL, 32'h4);
    $display("registers done");
  endtask : t_regs
  task automatic t_nap();
    core.wait_for_interrupt_instr();
    #1 chk("core clk nap", 1'b0, CORE_CLK_EN);
    chk("periph nap", BUS_CLOCK_GATES, PERIPH_CLK_EN);
    chk("pin hold nap", 1'b1, PIN_HOLD);
    core.irq();
    #1 chk("core clk irq", 1'b1, CORE_CLK_EN);
    core.wait_for_interrupt_instr();
    @(posedge CLK);
    EXT_RESET_N <= 1'b0;
    @(posedge CLK);
    EXT_RESET_N <= 1'b1;
    #1 chk("reset in nap", 1'b1, SYS_RESET);
    for (int i = 0; i < 50 && SYS_RESET; i++) @(posedge CLK);
    $display("light nap done");
  endtask : t_nap
  task automatic t_deep();
    axw(OFS_MODE_CTRL, 32'h6);
    axw(OFS_WAKE_POL, 32'h0);
    axw(OFS_WAKE_EN, 32'h8);
    core.wait_for_interrupt_instr();
    #1 chk("periph deep", 32'h0, PERIPH_CLK_EN);
    chk("fast osc deep", 1'b0, FAST_OSC_EN);
    chk("slow osc deep", 1'b1, SLOW_OSC_EN);
    chk("flash deep", 1'b0, FLASH_PWR_EN);
    core.irq();
    #1 chk("irq in deep", 1'b0, FLASH_PWR_EN);
    @(posedge CLK);
    WAKE_PINS <= 12'hFF7;
    repeat (3) @(posedge CLK);
    #1 chk("wake line", 1'b1, WAKE_IRQ0);
    chk("no enable", 1'b0, FLASH_PWR_EN);
    @(posedge CLK);
    IRQ0_ENABLED <= 1'b1;
    @(posedge CLK);
    #1 chk("flash wake", 1'b1, FLASH_PWR_EN);
    repeat (FLASH_WAKE_CYC - 1) @(posedge CLK);
    #1 chk("core held", 1'b0, CORE_CLK_EN);
    @(posedge CLK);
    #1 chk("core run", 1'b1, CORE_CLK_EN);
    @(posedge CLK);
    IRQ0_ENABLED <= 1'b0;
    WAKE_PINS <= 12'hFFF;
    axw(OFS_WAKE_FLAGS, 32'h8);
    #1 chk("wake cleared", 1'b0, WAKE_IRQ0);
    // RTC interrupt alone must also end deep nap
    core.wait_for_interrupt_instr();
    @(posedge CLK);
    RTC_IRQ <= 1'b1;
    @(posedge CLK);
    RTC_IRQ <= 1'b0;
    #1 chk("rtc wake", 1'b1, FLASH_PWR_EN);
    axr(OFS_STATUS);
    chk("status flash wake", 32'h3, rd);
    repeat (FLASH_WAKE_CYC) @(posedge CLK);
    #1 chk("rtc run", 1'b1, CORE_CLK_EN);
    $display("deep nap done");
  endtask : t_deep
  task automatic t_off();
    axw(OFS_SCRATCH0 + 8'h08, 32'h5A);
    axw(OFS_MODE_CTRL, 32'h7);
    repeat (801) @(posedge CLK);
    core.wait_for_interrupt_instr();
    #1 chk("regulator off", 1'b0, REGULATOR_EN);
    @(posedge CLK);
    EXT_RESET_N <= 1'b0;
    repeat (2) @(posedge CLK);
    EXT_RESET_N <= 1'b1;
    #1 chk("reset in off", 1'b0, SYS_RESET | REGULATOR_EN);
    core.pin(1'b0);
    @(posedge CLK);
    #1 chk("regulator on", 1'b1, REGULATOR_EN);
    for (int i = 0; i < 50 && !SYS_RESET; i++) @(posedge CLK);
    chk("boot reset", 1'b1, SYS_RESET);
    for (int i = 0; i < 50 && SYS_RESET; i++) @(posedge CLK);
    axr(OFS_MODE_CTRL);
    chk("mode kept", 32'h7, rd);
    axr(OFS_SCRATCH0 + 8'h08);
    chk("scratch kept", 32'h5A, rd);
    axr(OFS_WAKE_EN);
    chk("wake en cleared", 32'h0, rd);
    axw(OFS_MODE_CTRL, 32'h0);
    core.pin(1'b1);
    $display("full off done");
  endtask : t_off
  // Watchdog cuts a hang short
  initial begin
    repeat (20000) @(posedge CLK);
    errors++;
    $display("watchdog expired");
    report_and_stop();
  end
  // Main sequence
  initial begin
    {NRST, AWVALID, WVALID, BREADY, ARVALID, RREADY, IRQ0_ENABLED, RTC_IRQ} = 8'h00;
    {CE, RTC_SLOW_CLK_USED, EXT_RESET_N} = 3'h7;
    {AWADDR, ARADDR, WDATA, WSTRB} = {16'h0000, 32'h0, 4'hF};
    BUS_CLOCK_GATES = 32'h0000_A5C3;
    WAKE_PINS = 12'hFFF;
    errors = 0;
    compares = 0;
    repeat (12) @(posedge CLK);
    NRST <= 1'b1;
    repeat (2) @(posedge CLK);
    t_regs();
    t_nap();
    t_deep();
    t_off();
    report_and_stop();
  end
endmodule : low_power_mode_controller_tb_top
